// ===== hw/dual_port_serial_field_fifo.sv
`timescale 1ns/1ps
module dual_port_serial_field_fifo (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_clock,
  input wire logic i_wr_advance_gate,
  input wire logic i_wr_data_mask,
  input wire logic i_wr_pointer_clear,
  input wire logic [field_fifo_pkg::DATA_W-1:0] i_wr_data_in,
  input wire logic i_rd_clock,
  input wire logic i_rd_advance_gate,
  input wire logic i_rd_output_pass,
  input wire logic i_rd_pointer_clear,
  output logic [field_fifo_pkg::DATA_W-1:0] o_rd_data_out,
  output logic o_rd_data_oe,
  output logic o_wr_ready
);
  localparam int AW = field_fifo_pkg::ADDR_W;
  localparam int DW = field_fifo_pkg::DATA_W;

  default clocking dflt_cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Write port edge tracking
  logic wr_clock_prev_r; // Write clock seen last cycle
  logic wr_edge; // Rising write clock
  logic wr_clear_last_r; // Clear level at previous write edge
  // Write stage, one clock behind the port edge
  logic st_vld_r; // Staged write edge pending
  logic st_clear_r; // Staged edge is a clear
  logic st_gate_r; // Staged advance gate
  logic st_mask_r; // Staged data mask
  logic [DW-1:0] st_data_r; // Staged input word
  logic [AW-1:0] wr_ptr_r; // Write address pointer
  logic st_active; // Staged edge advances pointer
  // Read port edge tracking
  logic rd_clock_prev_r; // Read clock seen last cycle
  logic rd_edge; // Rising read clock
  logic rd_clear_last_r; // Clear level at previous read edge
  logic rd_clear_now; // This read edge is a clear
  logic rd_active; // This read edge fetches a word
  logic [AW-1:0] rd_ptr_r; // Read address pointer
  logic rd_fetch_r; // Fetched word lands this cycle
  logic [DW-1:0] store_q; // Array read word
  // Storage arbitration
  field_fifo_pkg::arb_state_t arb_r; // Arbiter state
  logic [field_fifo_pkg::REFRESH_CNT_W-1:0] refresh_cnt_r; // To next slot
  logic refresh_due; // Refresh slot requested
  logic commit_en; // Buffered write goes to array

  // Buffer streams
  stream_if #(.W(field_fifo_pkg::BUF_W)) buf_in ();
  stream_if #(.W(field_fifo_pkg::BUF_W)) buf_out ();

  // Edge detect on each port clock
  assign wr_edge = i_wr_clock & ~wr_clock_prev_r;
  assign rd_edge = i_rd_clock & ~rd_clock_prev_r;

  // Previous port clock levels
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_clock_prev_r <= 1'b0;
      rd_clock_prev_r <= 1'b0;
    end else begin
      wr_clock_prev_r <= i_wr_clock;
      rd_clock_prev_r <= i_rd_clock;
    end
  end

  // Capture write pins at the edge, acted on one clock later
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_vld_r <= 1'b0;
      st_clear_r <= 1'b0;
      st_gate_r <= 1'b0;
      st_mask_r <= 1'b0;
      st_data_r <= field_fifo_pkg::DOUT_RESET;
      wr_clear_last_r <= 1'b0;
    end else begin
      st_vld_r <= wr_edge;
      if (wr_edge) begin
        // Only the first edge of a high clear level clears
        st_clear_r <= i_wr_pointer_clear & ~wr_clear_last_r;
        st_gate_r <= i_wr_advance_gate;
        st_mask_r <= i_wr_data_mask;
        st_data_r <= i_wr_data_in;
        wr_clear_last_r <= i_wr_pointer_clear;
      end
    end
  end

  // Clear cycle overrides gate and mask
  assign st_active = st_vld_r & ~st_clear_r & st_gate_r;

  // Write pointer update
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_r <= field_fifo_pkg::PTR_CLEAR;
    end else if (st_vld_r && st_clear_r) begin
      wr_ptr_r <= field_fifo_pkg::PTR_CLEAR;
    end else if (st_active) begin
      // Mask has no say in advancing
      wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
    end
    // Otherwise held, also while the clock is stopped
  end

  // Masked words are skipped, not stored
  assign buf_in.valid = st_active & st_mask_r;
  assign buf_in.data = {wr_ptr_r, st_data_r};
  // Back-pressure seen by the write partner
  assign o_wr_ready = buf_in.ready;

  // Write-commit buffer
  commit_fifo #(
    .WIDTH(field_fifo_pkg::BUF_W),
    .DEPTH(field_fifo_pkg::BUF_DEPTH)
  ) u_commit (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .in_s(buf_in.snk),
    .out_s(buf_out.src)
  );

  // Refresh slot timer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      refresh_cnt_r <= field_fifo_pkg::REFRESH_RESET;
    end else if (refresh_cnt_r == '0) begin
      refresh_cnt_r <= field_fifo_pkg::REFRESH_LOAD;
    end else begin
      refresh_cnt_r <= refresh_cnt_r - 1'b1;
    end
  end

  assign refresh_due = (refresh_cnt_r == '0);

  // Arbiter: a refresh slot takes the array for one cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arb_r <= field_fifo_pkg::ARB_IDLE;
    end else begin
      unique case (arb_r)
        field_fifo_pkg::ARB_IDLE: begin
          if (refresh_due) begin
            arb_r <= field_fifo_pkg::ARB_REFRESH;
          end
        end
        field_fifo_pkg::ARB_REFRESH: begin
          arb_r <= field_fifo_pkg::ARB_IDLE;
        end
        default: begin
          arb_r <= field_fifo_pkg::ARB_IDLE;
        end
      endcase
    end
  end

  // Buffered writes drain outside refresh slots
  assign buf_out.ready = (arb_r == field_fifo_pkg::ARB_IDLE);
  assign commit_en = buf_out.valid & buf_out.ready;

  // Read edge decode
  assign rd_clear_now = rd_edge & i_rd_pointer_clear & ~rd_clear_last_r;
  assign rd_active = rd_edge & ~rd_clear_now & i_rd_advance_gate;

  // Remember clear level at each read edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_clear_last_r <= 1'b0;
    end else if (rd_edge) begin
      rd_clear_last_r <= i_rd_pointer_clear;
    end
  end

  // Read pointer update
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_ptr_r <= field_fifo_pkg::PTR_CLEAR;
    end else if (rd_clear_now) begin
      rd_ptr_r <= field_fifo_pkg::PTR_CLEAR;
    end else if (rd_active) begin
      // Pass control has no say in advancing
      rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
    end
  end

  // Storage array; reads never wait on refresh or commits
  field_store u_store (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr_en(commit_en),
    .i_wr_addr(buf_out.data[field_fifo_pkg::BUF_W-1:DW]),
    .i_wr_data(buf_out.data[DW-1:0]),
    .i_rd_en(rd_active),
    .i_rd_addr(rd_ptr_r),
    .o_rd_data(store_q)
  );

  // Fetched word arrives one clock after the edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_fetch_r <= 1'b0;
    end else begin
      rd_fetch_r <= rd_active;
    end
  end

  // Output word, same polarity as stored
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data_out <= field_fifo_pkg::DOUT_RESET;
    end else if (rd_fetch_r) begin
      o_rd_data_out <= store_q;
    end
  end

  // Output drive enable, sampled on non-clear read edges
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data_oe <= 1'b0;
    end else if (rd_edge && !rd_clear_now) begin
      o_rd_data_oe <= i_rd_output_pass;
    end
  end

  // Staged write follows the port edge by exactly one clock
  AST_WR_DELAY: assert property (wr_edge |=> st_vld_r)
    else $error("write stage missed its edge");

  // Write clear zeroes the pointer
  AST_WR_CLEAR: assert property (st_vld_r && st_clear_r |=>
    wr_ptr_r == '0)
    else $error("write pointer not cleared");

  // Gate low holds the write pointer
  AST_WR_HOLD: assert property (st_vld_r && !st_clear_r && !st_gate_r
    |=> $stable(wr_ptr_r))
    else $error("write pointer moved with gate low");

  // Gate high advances by one, mask or not
  AST_WR_ADV: assert property (st_active |=>
    wr_ptr_r == AW'($past(wr_ptr_r) + 1'b1))
    else $error("write pointer did not advance by one");

  // Masked words never reach the buffer
  AST_WR_MASK: assert property (st_vld_r && !st_mask_r |->
    !buf_in.valid)
    else $error("masked word entered buffer");

  // Clear edge ignores gate: nothing buffered
  AST_WR_CLR_IGN: assert property (st_vld_r && st_clear_r |->
    !buf_in.valid)
    else $error("write clear cycle stored data");

  // Read clear zeroes the pointer, oe untouched
  AST_RD_CLEAR: assert property (rd_clear_now |=>
    rd_ptr_r == '0 && $stable(o_rd_data_oe))
    else $error("read clear misbehaved");

  // Read gate low holds pointer and output word
  AST_RD_HOLD: assert property (rd_edge && !rd_clear_now
    && !i_rd_advance_gate |=> $stable(rd_ptr_r) ##1 $stable(o_rd_data_out))
    else $error("read pointer moved with gate low");

  // Output enable follows the pass control
  AST_RD_PASS: assert property (rd_edge && !rd_clear_now |=>
    o_rd_data_oe == $past(i_rd_output_pass))
    else $error("output enable wrong");

  // Fetched word shows two clocks after the edge
  AST_RD_WORD: assert property (rd_active |-> ##2
    o_rd_data_out == $past(store_q))
    else $error("output word not the fetched word");

  // Refresh slot blocks array commits
  AST_REFRESH: assert property (arb_r == field_fifo_pkg::ARB_REFRESH
    |-> !commit_en ##1 arb_r == field_fifo_pkg::ARB_IDLE)
    else $error("commit during refresh slot");

  // One refresh slot per interval
  AST_REF_SLOT: assert property (refresh_due |=>
    arb_r == field_fifo_pkg::ARB_REFRESH)
    else $error("refresh slot skipped");
endmodule : dual_port_serial_field_fifo

// ===== hw/field_fifo_pkg.sv
package field_fifo_pkg;
  // Word width of both serial ports
  localparam int DATA_W = 8;
  // Address width of the storage array
  localparam int ADDR_W = 18;
  // Words held: 2 Mbit organised as 8-bit words
  localparam int STORE_WORDS = 262144;
  // Words held by the write-commit buffer
  localparam int BUF_DEPTH = 16;
  // Width of one buffered write: address then data
  localparam int BUF_W = ADDR_W + DATA_W;
  // Pointer value after a pointer clear
  localparam logic [ADDR_W-1:0] PTR_CLEAR = 18'h0_0000;
  // Output word after reset
  localparam logic [DATA_W-1:0] DOUT_RESET = 8'h00;
  // System clock period in ns
  localparam int CLK_PERIOD_NS = 10;
  // Interval between refresh slots in ns
  localparam int REFRESH_NS = 15600;
  // Refresh interval in cycles, rounded down
  localparam int REFRESH_CYC = REFRESH_NS / CLK_PERIOD_NS;
  // Width of the refresh counter
  localparam int REFRESH_CNT_W = 11;
  // Reload value of the refresh counter
  localparam logic [REFRESH_CNT_W-1:0] REFRESH_LOAD =
    REFRESH_CNT_W'(REFRESH_CYC - 1);
  // Refresh counter value after reset
  localparam logic [REFRESH_CNT_W-1:0] REFRESH_RESET = 11'h000;

  // Storage arbiter states
  typedef enum logic [1:0] {
    ARB_IDLE    = 2'b01,
    ARB_REFRESH = 2'b10
  } arb_state_t;
endpackage : field_fifo_pkg

// ===== hw/stream_if.sv
`timescale 1ns/1ps
// Valid/ready word stream between the block's own modules
interface stream_if #(parameter int W = 8);
  logic valid; // Word offered
  logic ready; // Word accepted when valid
  logic [W-1:0] data; // Word carried
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// ===== hw/commit_fifo.sv
`timescale 1ns/1ps
module commit_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int IW = $clog2(DEPTH);
  localparam int CW = IW + 1;
  logic [WIDTH-1:0] mem_r [DEPTH]; // Word storage
  logic [IW-1:0] wr_idx_r; // Fill index
  logic [IW-1:0] rd_idx_r; // Drain index
  logic [CW-1:0] count_r; // Words held
  logic push; // Word taken in
  logic pop; // Word handed out

  // Honest full and empty
  assign in_s.ready = (count_r != CW'(DEPTH));
  assign out_s.valid = (count_r != '0);
  assign out_s.data = mem_r[rd_idx_r];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  // Storage write, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_idx_r] <= in_s.data;
    end
  end

  // Indices wrap at the depth
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
    end else begin
      if (push) begin
        wr_idx_r <= (wr_idx_r == IW'(DEPTH - 1)) ? '0 : IW'(wr_idx_r + 1'b1);
      end
      if (pop) begin
        rd_idx_r <= (rd_idx_r == IW'(DEPTH - 1)) ? '0 : IW'(rd_idx_r + 1'b1);
      end
    end
  end

  // Occupancy count
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_r <= '0;
    end else if (push && !pop) begin
      count_r <= CW'(count_r + 1'b1);
    end else if (pop && !push) begin
      count_r <= CW'(count_r - 1'b1);
    end
  end
endmodule : commit_fifo

// ===== hw/field_store.sv
`timescale 1ns/1ps
module field_store (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic [field_fifo_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [field_fifo_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [field_fifo_pkg::ADDR_W-1:0] i_rd_addr,
  output logic [field_fifo_pkg::DATA_W-1:0] o_rd_data
);
  // Whole field array
  logic [field_fifo_pkg::DATA_W-1:0] mem_r [field_fifo_pkg::STORE_WORDS];

  // Array write
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem_r[i_wr_addr] <= i_wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= field_fifo_pkg::DOUT_RESET;
    end else if (i_rd_en) begin
      o_rd_data <= mem_r[i_rd_addr];
    end
  end
endmodule : field_store

// ===== tb/video_port_model.sv
`timescale 1ns/1ps
// Upstream writer and downstream reader of the field memory
module video_port_model (
  input wire logic i_clk,
  output logic o_wr_clock,
  output logic o_wr_gate,
  output logic o_wr_mask,
  output logic o_wr_clear,
  output logic [field_fifo_pkg::DATA_W-1:0] o_wr_data,
  output logic o_rd_clock,
  output logic o_rd_gate,
  output logic o_rd_pass,
  output logic o_rd_clear
);
  // Idle levels at time zero
  initial begin
    o_wr_clock = 1'b0;
    o_wr_gate = 1'b0;
    o_wr_mask = 1'b0;
    o_wr_clear = 1'b0;
    o_wr_data = 8'h00;
    o_rd_clock = 1'b0;
    o_rd_gate = 1'b0;
    o_rd_pass = 1'b0;
    o_rd_clear = 1'b0;
  end

  // One write clock period over two system cycles
  task automatic wr_cyc(input logic g, input logic m, input logic c,
      input logic [field_fifo_pkg::DATA_W-1:0] d);
    @(posedge i_clk);
    o_wr_clock <= 1'b1;
    o_wr_gate <= g;
    o_wr_mask <= m;
    o_wr_clear <= c;
    o_wr_data <= d;
    @(posedge i_clk);
    o_wr_clock <= 1'b0;
    // Clear dropped at once, callers space clears apart
    o_wr_clear <= 1'b0;
    // Data no longer held after the edge
    o_wr_data <= ~d;
  endtask : wr_cyc

  // One read clock period over two system cycles
  task automatic rd_cyc(input logic g, input logic p, input logic c);
    @(posedge i_clk);
    o_rd_clock <= 1'b1;
    o_rd_gate <= g;
    o_rd_pass <= p;
    o_rd_clear <= c;
    @(posedge i_clk);
    o_rd_clock <= 1'b0;
    // Clear low until the next requested clear
    o_rd_clear <= 1'b0;
  endtask : rd_cyc
endmodule : video_port_model

// ===== tb/dual_port_serial_field_fifo_test.sv
`timescale 1ns/1ps
// Self-checking bench for the field memory
module dual_port_serial_field_fifo_test;
  logic clk; // System clock
  logic rst; // Async reset
  logic wr_clock, wr_gate, wr_mask, wr_clear; // Write port pins
  logic [field_fifo_pkg::DATA_W-1:0] wr_data; // Write word
  logic rd_clock, rd_gate, rd_pass, rd_clear; // Read port pins
  logic [field_fifo_pkg::DATA_W-1:0] rd_data; // Output word
  logic rd_oe; // Output drive enable
  logic wr_ready; // Commit buffer space
  logic [field_fifo_pkg::DATA_W-1:0] exp_mem [0:99]; // Expected words
  int n_fail; // Mismatches
  int comparisons; // Compares made

  video_port_model u_model (.i_clk(clk), .o_wr_clock(wr_clock),
    .o_wr_gate(wr_gate), .o_wr_mask(wr_mask), .o_wr_clear(wr_clear),
    .o_wr_data(wr_data), .o_rd_clock(rd_clock), .o_rd_gate(rd_gate),
    .o_rd_pass(rd_pass), .o_rd_clear(rd_clear));

  dual_port_serial_field_fifo u_dut (.i_clk(clk), .i_rst(rst),
    .i_wr_clock(wr_clock), .i_wr_advance_gate(wr_gate),
    .i_wr_data_mask(wr_mask), .i_wr_pointer_clear(wr_clear),
    .i_wr_data_in(wr_data), .i_rd_clock(rd_clock),
    .i_rd_advance_gate(rd_gate), .i_rd_output_pass(rd_pass),
    .i_rd_pointer_clear(rd_clear), .o_rd_data_out(rd_data),
    .o_rd_data_oe(rd_oe), .o_wr_ready(wr_ready));

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Word compare
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
      input string what);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      n_fail++;
    end
  endtask : check_byte

  // Flag compare
  task automatic check_bit(input logic got, input logic exp,
      input string what);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
      n_fail++;
    end
  endtask : check_bit

  // Verdict and end of run
  task automatic stop_test();
    $display("Counts: %0d compared, %0d failed", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // Read edge, then wait until the word has landed
  task automatic rd_word(input logic g, input logic p, input logic c);
    u_model.rd_cyc(g, p, c);
    repeat (2) @(posedge clk);
    #1;
  endtask : rd_word

  // Reset values of the outputs
  task automatic t_reset();
    repeat (12) @(posedge clk);
    #1;
    check_bit(rd_oe, 1'b0, "oe in reset");
    check_byte(rd_data, 8'h00, "data in reset");
    check_bit(wr_ready, 1'b1, "ready in reset");
    @(posedge clk);
    rst <= 1'b0;
    $display("t_reset done");
  endtask : t_reset

  // Dummy cycles on both ports at once, then both clears
  task automatic t_init();
    fork
      for (int i = 0; i < 80; i++) u_model.wr_cyc(1'b1, 1'b1, 1'b0, 8'(i));
      for (int i = 0; i < 80; i++) u_model.rd_cyc(1'b1, 1'b0, 1'b0);
    join
    u_model.wr_cyc(1'b0, 1'b0, 1'b1, 8'h00);
    rd_word(1'b1, 1'b0, 1'b1);
    $display("t_init done");
  endtask : t_init

  // Full field, then a field with gate and mask gaps
  task automatic t_write();
    int wp;
    logic g;
    logic m;
    for (int i = 0; i < 100; i++) begin
      u_model.wr_cyc(1'b1, 1'b1, 1'b0, 8'h5A ^ 8'(i));
      exp_mem[i] = 8'h5A ^ 8'(i);
    end
    // Clear edge with gate and mask high must not store or advance
    u_model.wr_cyc(1'b1, 1'b1, 1'b1, 8'hFF);
    wp = 0;
    for (int i = 0; i < 100; i++) begin
      g = (i % 7 != 3);
      m = (i % 5 != 2);
      u_model.wr_cyc(g, m, 1'b0, 8'(i * 3 + 1));
      if (g && m) exp_mem[wp] = 8'(i * 3 + 1);
      if (g) wp++;
    end
    u_model.wr_cyc(1'b0, 1'b0, 1'b1, 8'h00);
    repeat (40) @(posedge clk);
    $display("t_write done");
  endtask : t_write

  // Read back with gate and pass gaps
  task automatic t_read();
    int rp;
    logic g;
    logic p;
    rp = 0;
    // Clear held low over two read edges before clearing again
    repeat (2) rd_word(1'b0, 1'b0, 1'b0);
    rd_word(1'b1, 1'b1, 1'b1);
    check_bit(rd_oe, 1'b0, "oe held on clear");
    for (int i = 0; i < 100; i++) begin
      g = (i % 9 != 4);
      p = (i % 6 != 5);
      rd_word(g, p, 1'b0);
      check_bit(rd_oe, p, "oe follows pass");
      if (g && p) check_byte(rd_data, exp_mem[rp], "word");
      if (!g) check_byte(rd_data, exp_mem[rp - 1], "gate low hold");
      if (g) rp++;
    end
    $display("t_read done");
  endtask : t_read

  // Clear, first words, long clock stop, then the rest
  task automatic t_stop();
    rd_word(1'b1, 1'b0, 1'b1);
    check_bit(rd_oe, 1'b1, "oe held on clear");
    for (int k = 0; k < 82; k++) begin
      if (k == 2) repeat (3300) @(posedge clk);
      rd_word(1'b1, 1'b1, 1'b0);
      check_byte(rd_data, exp_mem[k], "word");
    end
    $display("t_stop done");
  endtask : t_stop

  // Field through the commit buffer, then read back in order
  task automatic t_buffer();
    int n;
    int r;
    n = 0;
    r = 0;
    // Clear low over two write edges, then a fresh clear
    repeat (2) u_model.wr_cyc(1'b0, 1'b0, 1'b0, 8'h00);
    u_model.wr_cyc(1'b0, 1'b0, 1'b1, 8'h00);
    for (int k = 0; k < 80; k++) begin
      u_model.wr_cyc(1'b1, 1'b1, 1'b0, 8'hC3 ^ 8'(k));
      exp_mem[k] = 8'hC3 ^ 8'(k);
      #1;
      check_bit(wr_ready, 1'b1, "buffer ready");
      if (wr_ready === 1'b1) n++;
    end
    u_model.wr_cyc(1'b0, 1'b0, 1'b1, 8'h00);
    repeat (40) @(posedge clk);
    check_byte(8'(n), 8'h50, "words taken");
    rd_word(1'b1, 1'b0, 1'b1);
    check_bit(rd_oe, 1'b1, "oe held on clear");
    for (int k = 0; k < 80; k++) begin
      rd_word(1'b1, 1'b1, 1'b0);
      check_byte(rd_data, exp_mem[k], "drain order");
      if (rd_data === exp_mem[k]) r++;
    end
    check_byte(8'(r), 8'h50, "words drained");
    check_bit(wr_ready, 1'b1, "empty buffer ready");
    $display("t_buffer done");
  endtask : t_buffer

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    $display("[FAIL] %0t run limit reached", $time);
    n_fail++;
    stop_test();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    n_fail = 0;
    comparisons = 0;
    t_reset();
    t_init();
    t_write();
    t_read();
    t_stop();
    t_buffer();
    stop_test();
  end
endmodule : dual_port_serial_field_fifo_test
